// ---- pkg/pml_pkg.sv ----
// constants and types shared by the protection mode lock device and host ends
// assumes a single 100 MHz system clock on both ends
// Summary of operation
// - 16-bit lock register, bits only go 1 to 0
// - lock bits 2 and 1 choose the mode
// - both mode bits one means solid mode
// - lock register changes only by its write command
// - bit 1 zero fixes solid mode forever
// - bit 2 zero fixes password mode forever
// - clearing both mode bits at once aborts
// - write needs write enable latch set first
// - host stores password before choosing password mode
// - password taken by its own write command
// - after one mode bit programmed, other frozen
// - solid protect bit one protects its region
// - unmask zero masks all solid protect bits
// - after reset modify lock one solid, zero password
// - entering password mode forces modify lock zero
// - scheme select zero disables all protection commands
package pml_pkg;
	localparam int LOCK_W = 16;
	localparam int PWD_W = 64;
	localparam int REGION_N = 542;
	localparam int IDX_W = 10;
	localparam int SOLID_BIT = 1;
	localparam int PWD_BIT = 2;
	localparam logic [15:0] LOCK_RESET = 16'hFFFF;
	localparam logic [15:0] LOCK_MODE_MASK = 16'h0006;
	localparam logic [9:0] BOTTOM_LAST = 10'h00F;
	localparam logic [9:0] BLOCK_LAST = 10'h20D;
	localparam logic [9:0] TOP_LAST = 10'h21D;
	typedef enum logic [2:0] {
		PML_CMD_NONE,
		PML_CMD_WREN,
		PML_CMD_WRLOCK,
		PML_CMD_WRPWD,
		PML_CMD_LKCLR
	} pml_cmd_e;
	typedef enum logic [1:0] {
		PML_REGION_BOTTOM,
		PML_REGION_BLOCK,
		PML_REGION_TOP,
		PML_REGION_NONE
	} pml_region_e;
endpackage

// ---- pkg/pml_if.sv ----
// command link between host controller and protection mode logic
// assumes both ends share sys_clk_i
`timescale 1ns/100ps
`default_nettype none
interface pml_if;
	logic cmd_valid;
	pml_pkg::pml_cmd_e cmd;
	logic [15:0] wr_data;
	logic [63:0] pwd_data;
	logic done;
	logic accepted;
	logic [15:0] lock_value;
	logic password_mode;
	modport device (input cmd_valid, input cmd, input wr_data, input pwd_data,
		output done, output accepted, output lock_value, output password_mode);
	modport host (output cmd_valid, output cmd, output wr_data, output pwd_data,
		input done, input accepted, input lock_value, input password_mode);
endinterface
`default_nettype wire

// ---- logic/pml_device.sv ----
// device end: one-time lock register, mode choice and solid bit gating
// assumes one command at a time from the host, each held until done
`timescale 1ns/100ps
`default_nettype none
module pml_device (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	pml_if.device link,
	input wire logic protect_scheme_select_i,
	input wire logic [9:0] region_idx_i,
	input wire logic solid_protect_bit_i,
	input wire logic dynamic_protect_bit_i,
	input wire logic solid_bits_unmask_i,
	output logic write_enable_latch_o,
	output logic solid_bits_modify_lock_o,
	output logic region_protected_o,
	output logic [1:0] region_kind_o,
	output logic [63:0] password_o
);
	logic [15:0] lock_reg;
	logic write_enable_latch;
	logic boot;
	logic next_accept;
	logic [15:0] next_lock;
	logic [1:0] new_mode;

	// map a protect bit index onto its region kind
	function automatic logic [1:0] region_of(input logic [9:0] idx);
		if (idx <= pml_pkg::BOTTOM_LAST)
			region_of = pml_pkg::PML_REGION_BOTTOM;
		else if (idx <= pml_pkg::BLOCK_LAST)
			region_of = pml_pkg::PML_REGION_BLOCK;
		else if (idx <= pml_pkg::TOP_LAST)
			region_of = pml_pkg::PML_REGION_TOP;
		else
			region_of = pml_pkg::PML_REGION_NONE;
	endfunction

	// decide whether a lock write may be programmed and its result
	always_comb
	begin
		new_mode = lock_reg[2:1] & link.wr_data[2:1];
		next_lock = {lock_reg[15:3], new_mode, lock_reg[0]};
		next_accept = 1'b0;
		if (link.cmd_valid && !link.done && protect_scheme_select_i)
		begin
			case (link.cmd)
				pml_pkg::PML_CMD_WREN: next_accept = 1'b1;
				pml_pkg::PML_CMD_WRPWD: next_accept = write_enable_latch && lock_reg[2];
				pml_pkg::PML_CMD_LKCLR: next_accept = write_enable_latch;
				pml_pkg::PML_CMD_WRLOCK:
					next_accept = write_enable_latch
						&& (new_mode != 2'b00)
						&& (lock_reg[2:1] == 2'b11 || new_mode == lock_reg[2:1]);
				default: next_accept = 1'b0;
			endcase
		end
	end

	// lock register, changed only by an accepted lock write
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			lock_reg <= pml_pkg::LOCK_RESET;
		else if (next_accept && link.cmd == pml_pkg::PML_CMD_WRLOCK)
			lock_reg <= next_lock;
	end

	// write enable latch: set by enable, cleared after any other attempt, both only while scheme select is one
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			write_enable_latch <= 1'b0;
		else if (link.cmd_valid && !link.done && protect_scheme_select_i)
			write_enable_latch <= (link.cmd == pml_pkg::PML_CMD_WREN);
	end

	// password register
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			password_o <= '0;
		else if (next_accept && link.cmd == pml_pkg::PML_CMD_WRPWD)
			password_o <= link.pwd_data;
	end

	// modify lock: preset one cycle after reset from lock bit 2
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			boot <= 1'b1;
			solid_bits_modify_lock_o <= 1'b0;
		end
		else
		begin
			boot <= 1'b0;
			if (boot)
				solid_bits_modify_lock_o <= lock_reg[2];
			else if (next_accept && link.cmd == pml_pkg::PML_CMD_WRLOCK && !next_lock[2])
				solid_bits_modify_lock_o <= 1'b0;
			else if (next_accept && link.cmd == pml_pkg::PML_CMD_LKCLR)
				solid_bits_modify_lock_o <= 1'b0;
		end
	end

	// command answer and status back to the host
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			link.done <= 1'b0;
			link.accepted <= 1'b0;
			link.lock_value <= pml_pkg::LOCK_RESET;
			link.password_mode <= 1'b0;
			write_enable_latch_o <= 1'b0;
		end
		else
		begin
			link.done <= link.cmd_valid && !link.done;
			link.accepted <= next_accept;
			link.lock_value <= (link.cmd_valid && next_accept && link.cmd == pml_pkg::PML_CMD_WRLOCK)
				? next_lock : lock_reg;
			link.password_mode <= !lock_reg[2];
			write_enable_latch_o <= write_enable_latch;
		end
	end

	// region protection from dynamic bit and unmasked solid bit
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			region_protected_o <= 1'b1;
			region_kind_o <= pml_pkg::PML_REGION_NONE;
		end
		else
		begin
			region_protected_o <= dynamic_protect_bit_i
				|| (solid_protect_bit_i && solid_bits_unmask_i);
			region_kind_o <= region_of(region_idx_i);
		end
	end
endmodule
`default_nettype wire

// ---- logic/pml_host.sv ----
// host end: issues write enable then the chosen protection command
// assumes the device answers each command with a one-cycle done
`timescale 1ns/100ps
`default_nettype none
module pml_host (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	pml_if.host link,
	input wire logic req_i,
	input wire logic [2:0] req_cmd_i,
	input wire logic [15:0] req_lock_i,
	input wire logic [63:0] req_pwd_i,
	output logic busy_o,
	output logic done_o,
	output logic ok_o,
	output logic [15:0] lock_o
);
	typedef enum logic [1:0] {PML_H_IDLE, PML_H_WREN, PML_H_CMD} pml_hstate_e;
	pml_hstate_e state;
	pml_pkg::pml_cmd_e saved;
	logic pwd_stored;

	// sequence: enable latch first, then the command itself
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state <= PML_H_IDLE;
			saved <= pml_pkg::PML_CMD_NONE;
			link.cmd_valid <= 1'b0;
			link.cmd <= pml_pkg::PML_CMD_NONE;
			link.wr_data <= '0;
			link.pwd_data <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			ok_o <= 1'b0;
			lock_o <= pml_pkg::LOCK_RESET;
			pwd_stored <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			case (state)
				PML_H_IDLE:
				begin
					if (req_i)
					begin
						saved <= pml_pkg::pml_cmd_e'(req_cmd_i);
						link.wr_data <= req_lock_i;
						link.pwd_data <= req_pwd_i;
						link.cmd <= pml_pkg::PML_CMD_WREN;
						link.cmd_valid <= 1'b1;
						busy_o <= 1'b1;
						state <= PML_H_WREN;
					end
				end
				PML_H_WREN:
				begin
					if (link.done)
					begin
						// password mode only after a password was stored
						if (saved == pml_pkg::PML_CMD_WRLOCK && !link.wr_data[2] && !pwd_stored)
							link.wr_data[2] <= 1'b1;
						link.cmd <= saved;
						state <= PML_H_CMD;
						link.cmd_valid <= 1'b0;
					end
				end
				PML_H_CMD:
				begin
					link.cmd_valid <= !link.done;
					if (link.done)
					begin
						if (saved == pml_pkg::PML_CMD_WRPWD && link.accepted)
							pwd_stored <= 1'b1;
						ok_o <= link.accepted;
						lock_o <= link.lock_value;
						done_o <= 1'b1;
						busy_o <= 1'b0;
						link.cmd <= pml_pkg::PML_CMD_NONE;
						state <= PML_H_IDLE;
					end
				end
				default: state <= PML_H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- tb/pml_link_monitor.sv ----
// assertion checker watching the command link between host and device ends
// assumes it is instantiated beside the one link whose ends are both design modules
`timescale 1ns/100ps
`default_nettype none
module pml_link_monitor (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic cmd_valid,
	input var pml_pkg::pml_cmd_e cmd,
	input wire logic [15:0] wr_data,
	input wire logic done,
	input wire logic accepted,
	input wire logic [15:0] lock_value,
	input wire logic password_mode
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// handshake: one answer per command, one cycle wide
	chk_done_one_cycle: assert property (done |=> !done)
		else $error("done wider than one cycle");
	chk_cmd_answered: assert property (cmd_valid && !done |=> done)
		else $error("command not answered next cycle");
	chk_lock_only_clears: assert property ((lock_value & ~$past(lock_value)) == 16'h0000)
		else $error("lock bit returned to one");
	chk_lock_moves_on_done: assert property (!$stable(lock_value) |-> done)
		else $error("lock changed outside a command");
	chk_reserved_read_one: assert property (lock_value[15:3] == 13'h1FFF && lock_value[0])
		else $error("reserved lock bit changed");
	chk_mode_bits_never_both: assert property (lock_value[2:1] != 2'h0)
		else $error("both mode bits cleared");
	chk_both_clear_refused: assert property (done && cmd == pml_pkg::PML_CMD_WRLOCK
		&& wr_data[2:1] == 2'h0 |-> !accepted)
		else $error("double clear accepted");
	chk_solid_freezes_pwd: assert property (!lock_value[1] |=> lock_value[2])
		else $error("password bit changed in solid mode");
	chk_pwd_freezes_solid: assert property (!lock_value[2] |=> lock_value[1])
		else $error("solid bit changed in password mode");
	chk_pwd_mode_follows: assert property (!lock_value[2] |=> password_mode)
		else $error("password mode flag not set");
endmodule
`default_nettype wire

// ---- tb/tb_protection_mode_lock_register.sv ----
// testbench: host and device ends on one link, driven from host and region inputs
// assumes one 100 MHz clock and an active-low asynchronous reset on both ends
`timescale 1ns/100ps
`default_nettype none
module tb_protection_mode_lock_register;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req = 1'b0;
	logic [2:0] req_cmd = 3'h0;
	logic [15:0] req_lock = 16'h0000;
	logic [63:0] req_pwd = 64'h0000_0000_0000_0000;
	logic solid_protect_bit = 1'b0;
	logic dynamic_protect_bit = 1'b0;
	logic unmask = 1'b1;
	logic sel = 1'b1;
	logic [9:0] idx = 10'h000;
	logic busy, done, ok, write_enable_latch, mlock, prot;
	logic [15:0] lock;
	logic [1:0] kind;
	logic [63:0] pwd;
	int failures = 0;
	int n_checks = 0;
	pml_if u_link ();
	// free-running clock
	always #5 clk = ~clk;
	pml_host u_pml_host (.sys_clk_i(clk), .rst_n_i(rst_n), .link(u_link.host), .req_i(req),
		.req_cmd_i(req_cmd), .req_lock_i(req_lock), .req_pwd_i(req_pwd), .busy_o(busy),
		.done_o(done), .ok_o(ok), .lock_o(lock));
	pml_device u_pml_device (.sys_clk_i(clk), .rst_n_i(rst_n), .link(u_link.device),
		.protect_scheme_select_i(sel), .region_idx_i(idx), .solid_protect_bit_i(solid_protect_bit),
		.dynamic_protect_bit_i(dynamic_protect_bit), .solid_bits_unmask_i(unmask), .write_enable_latch_o(write_enable_latch),
		.solid_bits_modify_lock_o(mlock), .region_protected_o(prot), .region_kind_o(kind),
		.password_o(pwd));
	pml_link_monitor u_pml_link_monitor (.sys_clk_i(clk), .rst_n_i(rst_n),
		.cmd_valid(u_link.cmd_valid), .cmd(u_link.cmd), .wr_data(u_link.wr_data),
		.done(u_link.done), .accepted(u_link.accepted), .lock_value(u_link.lock_value),
		.password_mode(u_link.password_mode));
	// compare and count
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// wait for the host done pulse under a bounded count
	task automatic wait_done();
		repeat (20)
		begin
			@(posedge clk);
			#1;
			if (done === 1'b1)
				break;
		end
		check("host done", 1'b1, done);
	endtask
	// one host request, then its answer
	task automatic request(input pml_pkg::pml_cmd_e c, input logic [15:0] lk, input logic [63:0] pw);
		@(posedge clk);
		req <= 1'b1;
		req_cmd <= c;
		req_lock <= lk;
		req_pwd <= pw;
		@(posedge clk);
		req <= 1'b0;
		wait_done();
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// region kind at each boundary, then every protect bit combination
	task automatic test_region();
		logic [9:0] ids [7] = '{10'h000, 10'h00F, 10'h010, 10'h20D, 10'h20E, 10'h21D, 10'h21E};
		logic [1:0] kinds [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
		for (int i = 0; i < 7; i++)
		begin
			@(posedge clk);
			idx <= ids[i];
			repeat (2) @(posedge clk);
			#1;
			check("region kind", kinds[i], kind);
		end
		for (int m = 0; m < 8; m++)
		begin
			@(posedge clk);
			{dynamic_protect_bit, solid_protect_bit, unmask} <= m[2:0];
			repeat (2) @(posedge clk);
			#1;
			check("protected", m[2] | (m[1] & m[0]), prot);
		end
		$display("test_region done");
	endtask
	// factory state, then solid mode fixed; host keeps bit 2 without a password
	task automatic test_solid();
		check("modify lock", 1'b1, mlock);
		request(pml_pkg::PML_CMD_WRLOCK, 16'h0005, '0);
		check("solid ok", 1'b1, ok);
		check("solid lock", 16'hFFFD, lock);
		request(pml_pkg::PML_CMD_WRLOCK, 16'hFFFB, '0);
		check("pwd after solid", 16'hFFFD, u_link.lock_value);
		check("pwd mode", 1'b0, u_link.password_mode);
		$display("test_solid done");
	endtask
	// scheme select low refuses commands; a command without the latch is refused
	task automatic test_scheme();
		@(posedge clk);
		sel <= 1'b0;
		request(pml_pkg::PML_CMD_LKCLR, 16'hFFFF, '0);
		check("off ok", 1'b0, ok);
		check("off modify lock", 1'b1, mlock);
		@(posedge clk);
		req <= 1'b1;
		req_cmd <= pml_pkg::PML_CMD_LKCLR;
		@(posedge clk);
		req <= 1'b0;
		repeat (2) @(posedge clk);
		sel <= 1'b1;
		#1;
		check("busy", 1'b1, busy);
		wait_done();
		check("no latch ok", 1'b0, ok);
		check("no latch modify lock", 1'b1, mlock);
		request(pml_pkg::PML_CMD_LKCLR, 16'hFFFF, '0);
		check("clear ok", 1'b1, ok);
		check("clear modify lock", 1'b0, mlock);
		$display("test_scheme done");
	endtask
	// password stored, password mode chosen, solid bit then frozen
	task automatic test_password();
		do_reset();
		request(pml_pkg::PML_CMD_WRPWD, 16'hFFFF, 64'h0123_4567_89AB_CDEF);
		check("password", 64'h0123_4567_89AB_CDEF, pwd);
		request(pml_pkg::PML_CMD_WRLOCK, 16'hFFF9, '0);
		check("double clear ok", 1'b0, ok);
		check("double clear lock", 16'hFFFF, u_link.lock_value);
		request(pml_pkg::PML_CMD_WRLOCK, 16'hFFFB, '0);
		check("pwd lock", 16'hFFFB, lock);
		check("pwd mode", 1'b1, u_link.password_mode);
		check("modify lock", 1'b0, mlock);
		request(pml_pkg::PML_CMD_WRLOCK, 16'hFFFD, '0);
		check("solid after pwd", 16'hFFFB, u_link.lock_value);
		request(pml_pkg::PML_CMD_WRPWD, 16'hFFFF, 64'hFEDC_BA98_7654_3210);
		check("pwd write refused", 1'b0, ok);
		check("password kept", 64'h0123_4567_89AB_CDEF, pwd);
		$display("test_password done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		do_reset();
		test_region();
		test_solid();
		test_scheme();
		test_password();
		print_verdict();
	end
	// watchdog against a hung handshake
	initial
	begin
		#100000;
		failures++;
		print_verdict();
	end
endmodule
`default_nettype wire
